/* core/mcu_decoder_pkg.sv */
// Constants, register map and operation codes for the instruction decoder core.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package mcu_decoder_pkg;

	// ****************************************
	// Register map, byte addresses
	// ****************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ACCUM = 8'h04;
	localparam logic [7:0] OFF_FLAGS = 8'h08;
	localparam logic [7:0] OFF_BANK = 8'h0C;
	localparam logic [7:0] OFF_UPPER_LATCH = 8'h10;
	localparam logic [7:0] OFF_PTR0 = 8'h14;
	localparam logic [7:0] OFF_PTR1 = 8'h18;
	localparam logic [7:0] OFF_EXEC_STATUS = 8'h1C;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int FLAG_C = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z = 2;
	localparam int DEST_BIT = 7;
	localparam int PTR_MSB = 15;
	localparam int STAT_INSTR_LSB = 8;
	localparam logic RUN_RST = 1'b1;
	localparam logic [7:0] ACCUM_RST = 8'h00;
	localparam logic [2:0] FLAGS_RST = 3'h0;
	localparam logic [4:0] BANK_RST = 5'h00;
	localparam logic [6:0] LATCH_RST = 7'h00;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [5:0] IND_PORT_HI = 6'h00;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam logic [1:0] LAST_QUARTER = 2'h3;

	// ****************************************
	// Operations, grouped so ranges classify them
	// ****************************************
	typedef enum logic [5:0] {
		OP_NOP = 6'b000000, OP_ADD = 6'b000001, OP_ADDC = 6'b000010, OP_AND = 6'b000011,
		OP_ASR = 6'b000100, OP_LSL = 6'b000101, OP_LSR = 6'b000110, OP_CLR = 6'b000111,
		OP_COM = 6'b001000, OP_DEC = 6'b001001, OP_INC = 6'b001010, OP_IOR = 6'b001011,
		OP_MOV = 6'b001100, OP_RLC = 6'b001101, OP_RRC = 6'b001110, OP_SUB = 6'b001111,
		OP_SUBB = 6'b010000, OP_SWAP = 6'b010001, OP_XOR = 6'b010010, OP_DECSZ = 6'b010011,
		OP_INCSZ = 6'b010100, OP_MOVWF = 6'b010101, OP_BCF = 6'b010110, OP_BSF = 6'b010111,
		OP_BTSC = 6'b011000, OP_BTSS = 6'b011001, OP_ADDL = 6'b011010, OP_ANDL = 6'b011011,
		OP_IORL = 6'b011100, OP_MOVLW = 6'b011101, OP_SUBL = 6'b011110, OP_XORL = 6'b011111,
		OP_MOVLB = 6'b100000, OP_LATCH = 6'b100001
	} op_e;

	typedef enum logic [1:0] {
		ST_FETCH = 2'b00,
		ST_EXEC = 2'b01,
		ST_STALL = 2'b10
	} st_e;

endpackage

/* core/mcu_core_instruction_decoder.sv */
// Executes 14-bit instruction words: decode, file read, compute, write back.
// Assumes program memory offers words with valid/ready and a file bus answering in the read quarter.
//
// Summary of operation
// - File operand instructions read, modify, then store per destination bit.
// - The addressed file register is read even when it is only written.
// - Destination bit zero writes the accumulator, one writes the file register.
// - The file field is a 7-bit address, 0 to 127, in the current bank.
// - The bit field selects one of eight bits of the addressed register.
// - Don't-care bits are ignored; code generators should fill them with zero.
// - Pointer number selects one of two indirect pointers and matching access port.
// - Add with carry to file: one cycle, updates carry, nibble overflow, zero.
// - OR accumulator with file: one cycle, changes only zero.
// - Rotates through carry shift one place, change only carry, one cycle.
// - Subtract with borrow from file: one cycle, updates carry, nibble, zero.
// - Exclusive OR accumulator with file: one cycle, changes only zero.
// - Decrement/increment skip on zero result, change no flags, one or two cycles.
// - Bit tests skip the next instruction on their condition, no flag change.
// - Literal add and subtract use accumulator, result there, update three flags.
// - Literal AND, OR, XOR combine with accumulator, change only zero.
// - Load upper program latch writes a 7-bit literal, no flags.
// - Skips take two cycles; the second cycle acts as a no-operation.
// - Each instruction cycle spans four clock cycles.
// - Indirect port access adds one instruction cycle when pointer msb is set.
module mcu_core_instruction_decoder
	import mcu_decoder_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Program memory
	input wire logic [13:0] instr_i,
	input wire logic instr_valid_i,
	output logic instr_ready_o,
	// File register bus
	output logic [15:0] file_addr_o,
	output logic file_rd_o,
	output logic file_wr_o,
	output logic [7:0] file_wdata_o,
	input wire logic [7:0] file_rdata_i
);

	// ****************************************
	// Functions
	// ****************************************
	// Don't-care bits never reach a case choice below
	function automatic op_e decode_op(input logic [13:0] w);
		op_e o;
		o = OP_NOP;
		casez (w[13:8])
			6'b000111: o = OP_ADD;
			6'b111101: o = OP_ADDC;
			6'b000101: o = OP_AND;
			6'b110111: o = OP_ASR;
			6'b110101: o = OP_LSL;
			6'b110110: o = OP_LSR;
			6'b000001: o = OP_CLR;
			6'b001001: o = OP_COM;
			6'b000011: o = OP_DEC;
			6'b001010: o = OP_INC;
			6'b000100: o = OP_IOR;
			6'b001000: o = OP_MOV;
			6'b001101: o = OP_RLC;
			6'b001100: o = OP_RRC;
			6'b000010: o = OP_SUB;
			6'b111011: o = OP_SUBB;
			6'b001110: o = OP_SWAP;
			6'b000110: o = OP_XOR;
			6'b001011: o = OP_DECSZ;
			6'b001111: o = OP_INCSZ;
			6'b0100??: o = OP_BCF;
			6'b0101??: o = OP_BSF;
			6'b0110??: o = OP_BTSC;
			6'b0111??: o = OP_BTSS;
			6'b111110: o = OP_ADDL;
			6'b111100: o = OP_SUBL;
			6'b111001: o = OP_ANDL;
			6'b111000: o = OP_IORL;
			6'b111010: o = OP_XORL;
			6'b110000: o = OP_MOVLW;
			6'b110001: o = w[7] ? OP_LATCH : OP_NOP;
			6'b000000: o = w[7] ? OP_MOVWF : ((w[7:5] == 3'b001) ? OP_MOVLB : OP_NOP);
			default: o = OP_NOP;
		endcase
		return o;
	endfunction

	// Clear-to-accumulator has no file field, so it must not touch the file bus
	function automatic logic uses_file(input op_e o, input logic d);
		return (o >= OP_ADD) && (o <= OP_BTSS) && !((o == OP_CLR) && !d);
	endfunction

	function automatic logic dest_op(input op_e o);
		return (o >= OP_ADD) && (o <= OP_INCSZ);
	endfunction

	// Returns {carry out of bit 7, carry out of bit 3, sum}
	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [4:0] lo;
		logic [8:0] full;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		return {full[8], lo[4], full[7:0]};
	endfunction

	function automatic logic [15:0] wb_merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	// ****************************************
	// State
	// ****************************************
	st_e state;
	logic [1:0] q;
	logic [13:0] instr;
	op_e op;
	logic extra;
	logic skip_next;
	logic [7:0] operand;
	logic [7:0] res;
	logic res_c, res_dc, res_z, res_skip;
	logic [7:0] accum;
	logic flag_c, flag_dc, flag_z;
	logic [4:0] bank;
	logic [6:0] upper_latch;
	logic [15:0] ptr [2];
	logic run;
	logic [7:0] next_res;
	logic next_c, next_dc, next_z, next_skip;
	logic [9:0] sum;
	logic take, commit, to_file, to_acc, ind_sel, wr_en;

	// ****************************************
	// Sequencer
	// ****************************************
	assign instr_ready_o = (state == ST_FETCH) && run;
	assign take = instr_ready_o && instr_valid_i && ce_i;
	assign commit = (state == ST_EXEC) && (q == LAST_QUARTER) && ce_i;
	assign to_file = (dest_op(op) && instr[DEST_BIT]) || ((op >= OP_MOVWF) && (op <= OP_BSF));
	assign to_acc = (dest_op(op) && !instr[DEST_BIT]) || ((op >= OP_ADDL) && (op <= OP_XORL));
	assign ind_sel = (instr_i[6:1] == IND_PORT_HI);

	// Fetch counts as the first quarter, then three more; stall adds four
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_FETCH;
			q <= 2'h0;
		end else if (ce_i) begin
			case (state)
				ST_FETCH: begin
					if (take) begin
						state <= ST_EXEC;
						q <= 2'h1;
					end
				end
				ST_EXEC: begin
					q <= 2'(q + 2'h1);
					if (q == LAST_QUARTER) begin
						state <= extra ? ST_STALL : ST_FETCH;
					end
				end
				ST_STALL: begin
					q <= 2'(q + 2'h1);
					if (q == LAST_QUARTER) begin
						state <= ST_FETCH;
					end
				end
				default: begin
					state <= ST_FETCH;
					q <= 2'h0;
				end
			endcase
		end
	end

	// Word capture and operand address; a skipped word runs as a no-operation
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			instr <= 14'h0000;
			op <= OP_NOP;
			extra <= 1'b0;
			file_addr_o <= 16'h0000;
		end else if (take) begin
			instr <= instr_i;
			op <= skip_next ? OP_NOP : decode_op(instr_i);
			file_addr_o <= ind_sel ? ptr[instr_i[0]] : {4'h0, bank, instr_i[6:0]};
			extra <= !skip_next && uses_file(decode_op(instr_i), instr_i[DEST_BIT])
				&& ind_sel && ptr[instr_i[0]][PTR_MSB];
		end
	end

	// ****************************************
	// File read in second quarter, write in fourth
	// ****************************************
	assign file_rd_o = (state == ST_EXEC) && (q == 2'h1) && uses_file(op, instr[DEST_BIT]);
	assign file_wr_o = (state == ST_EXEC) && (q == LAST_QUARTER) && to_file;
	assign file_wdata_o = res;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			operand <= 8'h00;
		end else if (ce_i && file_rd_o) begin
			operand <= file_rdata_i;
		end
	end

	// ****************************************
	// Arithmetic and logic
	// ****************************************
	always_comb begin
		next_res = operand;
		next_c = flag_c;
		next_dc = flag_dc;
		next_z = 1'b0;
		next_skip = 1'b0;
		sum = 10'h000;
		case (op)
			OP_ADD: sum = add8(accum, operand, 1'b0);
			OP_ADDC: sum = add8(accum, operand, flag_c);
			OP_SUB: sum = add8(operand, ~accum, 1'b1);
			OP_SUBB: sum = add8(operand, ~accum, flag_c);
			OP_ADDL: sum = add8(accum, instr[7:0], 1'b0);
			OP_SUBL: sum = add8(instr[7:0], ~accum, 1'b1);
			default: sum = 10'h000;
		endcase
		case (op)
			OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_ADDL, OP_SUBL: begin
				{next_c, next_dc, next_res} = sum;
			end
			OP_AND: next_res = operand & accum;
			OP_ASR: {next_res, next_c} = {operand[7], operand};
			OP_LSL: {next_c, next_res} = {operand, 1'b0};
			OP_LSR: {next_res, next_c} = {1'b0, operand};
			OP_CLR: next_res = 8'h00;
			OP_COM: next_res = ~operand;
			OP_DEC: next_res = 8'(operand - 8'h01);
			OP_INC: next_res = 8'(operand + 8'h01);
			OP_IOR: next_res = operand | accum;
			OP_XOR: next_res = operand ^ accum;
			OP_RLC: {next_c, next_res} = {operand, flag_c};
			OP_RRC: {next_res, next_c} = {flag_c, operand};
			OP_SWAP: next_res = {operand[3:0], operand[7:4]};
			OP_MOVWF: next_res = accum;
			OP_DECSZ: next_res = 8'(operand - 8'h01);
			OP_INCSZ: next_res = 8'(operand + 8'h01);
			OP_BCF: next_res = operand & ~(8'h01 << instr[9:7]);
			OP_BSF: next_res = operand | (8'h01 << instr[9:7]);
			OP_BTSC: next_skip = !operand[instr[9:7]];
			OP_BTSS: next_skip = operand[instr[9:7]];
			OP_ANDL: next_res = instr[7:0] & accum;
			OP_IORL: next_res = instr[7:0] | accum;
			OP_XORL: next_res = instr[7:0] ^ accum;
			OP_MOVLW, OP_MOVLB, OP_LATCH: next_res = instr[7:0];
			default: next_res = operand;
		endcase
		if ((op == OP_DECSZ) || (op == OP_INCSZ)) begin
			next_skip = (next_res == 8'h00);
		end
		// Only these touch zero; rotates, skips and moves other than MOV leave it alone
		case (op)
			OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_ADDL, OP_SUBL, OP_AND, OP_ASR, OP_LSL, OP_LSR,
			OP_CLR, OP_COM, OP_DEC, OP_INC, OP_IOR, OP_XOR, OP_MOV, OP_ANDL, OP_IORL,
			OP_XORL: next_z = (next_res == 8'h00);
			default: next_z = flag_z;
		endcase
	end

	// Result latched in the third quarter so the write data comes from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			res <= 8'h00;
			{res_c, res_dc, res_z, res_skip} <= 4'h0;
		end else if (ce_i && (state == ST_EXEC) && (q == 2'h2)) begin
			res <= next_res;
			{res_c, res_dc, res_z, res_skip} <= {next_c, next_dc, next_z, next_skip};
		end
	end

	// ****************************************
	// Architectural registers; core commit beats a bus write
	// ****************************************
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			accum <= ACCUM_RST;
		end else if (commit && to_acc) begin
			accum <= res;
		end else if (wr_en && (wb_adr_i == OFF_ACCUM)) begin
			accum <= wb_sel_i[0] ? wb_dat_i[7:0] : accum;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{flag_z, flag_dc, flag_c} <= FLAGS_RST;
		end else if (commit) begin
			{flag_z, flag_dc, flag_c} <= {res_z, res_dc, res_c};
		end else if (wr_en && (wb_adr_i == OFF_FLAGS) && wb_sel_i[0]) begin
			flag_c <= wb_dat_i[FLAG_C];
			flag_dc <= wb_dat_i[FLAG_DC];
			flag_z <= wb_dat_i[FLAG_Z];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bank <= BANK_RST;
			upper_latch <= LATCH_RST;
		end else if (commit && (op == OP_MOVLB)) begin
			bank <= res[4:0];
		end else if (commit && (op == OP_LATCH)) begin
			upper_latch <= res[6:0];
		end else if (wr_en && (wb_adr_i == OFF_BANK) && wb_sel_i[0]) begin
			bank <= wb_dat_i[4:0];
		end else if (wr_en && (wb_adr_i == OFF_UPPER_LATCH) && wb_sel_i[0]) begin
			upper_latch <= wb_dat_i[6:0];
		end
	end

	// Skip marker; its set at commit never meets the clear at fetch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			skip_next <= 1'b0;
		end else if (commit) begin
			skip_next <= res_skip;
		end else if (take) begin
			skip_next <= 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ptr
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					ptr[gi] <= PTR_RST;
				end else if (wr_en && (wb_adr_i == (gi ? OFF_PTR1 : OFF_PTR0))) begin
					ptr[gi] <= wb_merge(ptr[gi], wb_dat_i, wb_sel_i);
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run <= RUN_RST;
		end else if (wr_en && (wb_adr_i == OFF_CTRL) && wb_sel_i[0]) begin
			run <= wb_dat_i[0];
		end
	end

	// ****************************************
	// Wishbone answer: one wait state, unmapped reads zero
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			case (wb_adr_i)
				OFF_CTRL: wb_dat_o <= {31'h0, run};
				OFF_ACCUM: wb_dat_o <= {24'h0, accum};
				OFF_FLAGS: wb_dat_o <= {29'h0, flag_z, flag_dc, flag_c};
				OFF_BANK: wb_dat_o <= {27'h0, bank};
				OFF_UPPER_LATCH: wb_dat_o <= {25'h0, upper_latch};
				OFF_PTR0: wb_dat_o <= {16'h0, ptr[0]};
				OFF_PTR1: wb_dat_o <= {16'h0, ptr[1]};
				OFF_EXEC_STATUS: wb_dat_o <= {10'h0, instr, 6'h0, skip_next, state != ST_FETCH};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	sequence s_exec_quarters;
		(state == ST_EXEC) [*3] ##1 (state != ST_EXEC);
	endsequence

	a_read_before_write: assert property (file_wr_o |-> $past(file_rd_o, 2))
		else $error("file write without read two cycles earlier");
	a_instr_cycle_len: assert property (take |=> s_exec_quarters)
		else $error("instruction cycle not four clocks");
	a_dest_accum: assert property (commit && to_acc |=> accum == $past(res))
		else $error("accumulator not updated by result");
	a_dest_file: assert property (commit && to_file |-> file_wr_o && $past(file_rd_o, 2)
		&& file_wdata_o == res && file_addr_o == $past(file_addr_o, 2))
		else $error("file write-back missing");
	a_skip_nop: assert property (take && skip_next |=> op == OP_NOP && !file_rd_o)
		else $error("skipped word not executed as no-operation");
	a_indirect_stall: assert property (commit && extra |=> (state == ST_STALL) [*4])
		else $error("indirect extra cycle missing");
	a_or_flags: assert property (commit && op == OP_IOR |=> flag_c == $past(flag_c)
		&& flag_dc == $past(flag_dc) && flag_z == ($past(res) == 8'h00))
		else $error("inclusive or flag effect wrong");
	a_skip_zero: assert property (commit && (op == OP_DECSZ || op == OP_INCSZ)
		|=> skip_next == ($past(res) == 8'h00) && flag_z == $past(flag_z))
		else $error("skip on zero wrong");
	a_upper_latch: assert property (commit && op == OP_LATCH
		|=> upper_latch == $past(instr[6:0]))
		else $error("upper latch not loaded");

endmodule // mcu_core_instruction_decoder

/* test/prog_mem_model.sv */
// Program memory and file register model facing the decoder core.
// Assumes the bench queues words and presets file bytes by hierarchical access.
module prog_mem_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Instruction stream
	input wire logic instr_ready_i,
	output logic [13:0] instr_o,
	output logic instr_valid_o,
	// File register bus
	input wire logic [15:0] file_addr_i,
	input wire logic file_rd_i,
	input wire logic file_wr_i,
	input wire logic [7:0] file_wdata_i,
	output logic [7:0] file_rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [13:0] q[$];
	logic [7:0] mem [0:4095];
	logic [7:0] last_rd = 8'h00;
	logic [15:0] rd_addr = 16'h0000;
	int n_taken = 0;
	int n_rd = 0;
	int gap = 0;
	int since = 0;

	// ********
	// Word stream
	// ********
	// One word per take; gap counts clocks between takes
	always @(posedge clk_i) begin
		if (rst_i) begin
			instr_valid_o <= 1'b0;
			instr_o <= 14'h0000;
		end else begin
			since++;
			if (instr_valid_o && instr_ready_i) begin
				void'(q.pop_front());
				n_taken++;
				gap = since;
				since = 0;
			end
			instr_valid_o <= (q.size() != 0);
			instr_o <= (q.size() != 0) ? q[0] : ~instr_o; // Idle word never stale
		end
	end

	// ********
	// File registers
	// ********
	// Answer only in the strobe cycle; a released bus shows inverted data
	assign file_rdata_o = file_rd_i ? mem[file_addr_i[11:0]] : ~last_rd;

	// Reads are counted so hidden reads show up
	always @(posedge clk_i) begin
		if (file_rd_i) begin
			last_rd <= mem[file_addr_i[11:0]];
			rd_addr <= file_addr_i;
			n_rd++;
		end
		if (file_wr_i)
			mem[file_addr_i[11:0]] <= file_wdata_i;
	end
endmodule // prog_mem_model

/* test/testbench.sv */
// Self-checking bench for the instruction decoder core.
// Assumes the program memory model feeds words and holds the file registers.
module testbench import mcu_decoder_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i;
	logic rst_i;
	logic wb_cyc, wb_stb, wb_we, wb_ack_o;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat, wb_dat_o, q;
	logic instr_ready_o, instr_valid, file_rd_o, file_wr_o;
	logic [13:0] instr;
	logic [15:0] file_addr_o;
	logic [7:0] file_wdata_o, file_rdata;
	int err_total = 0;
	int n_tests = 0;
	int want = 0;

	// Free-running 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	mcu_core_instruction_decoder dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.instr_i(instr), .instr_valid_i(instr_valid), .instr_ready_o(instr_ready_o),
		.file_addr_o(file_addr_o), .file_rd_o(file_rd_o), .file_wr_o(file_wr_o),
		.file_wdata_o(file_wdata_o), .file_rdata_i(file_rdata)
	);

	prog_mem_model pm (
		.clk_i(clk_i), .rst_i(rst_i), .instr_ready_i(instr_ready_o),
		.instr_o(instr), .instr_valid_o(instr_valid), .file_addr_i(file_addr_o),
		.file_rd_i(file_rd_o), .file_wr_i(file_wr_o), .file_wdata_i(file_wdata_o),
		.file_rdata_o(file_rdata)
	);

	// ********
	// Shared tasks
	// ********
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		if (err_total == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Classic cycle; request held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (n >= 50)
			chk(32'h0, 32'h1);
	endtask

	// Queue filled off the clock edge so the model sees it race-free
	task automatic push(input logic [13:0] w);
		@(negedge clk_i);
		pm.q.push_back(w);
		want++;
	endtask

	// Wait until every queued word is taken and the core is idle
	task automatic settle();
		int n = 0;
		while (pm.n_taken < want && n < 300) begin
			@(negedge clk_i);
			n++;
		end
		repeat (2) @(negedge clk_i);
		while (instr_ready_o !== 1'b1 && n < 300) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 300)
			chk(32'h0, 32'h1);
	endtask

	task automatic lcase(input logic [13:0] w, input logic [7:0] wv, input logic [2:0] fl,
		input logic [7:0] r, input logic [2:0] rf);
		wb(1'b1, OFF_ACCUM, {24'h0, wv});
		wb(1'b1, OFF_FLAGS, {29'h0, fl});
		push(w);
		settle();
		wb(1'b0, OFF_ACCUM, 32'h0);
		chk(q, {24'h0, r});
		wb(1'b0, OFF_FLAGS, 32'h0);
		chk(q, {29'h0, rf});
	endtask

	task automatic fcase(input logic [13:0] w, input logic [7:0] fv, input logic [7:0] wv,
		input logic [2:0] fl, input logic [7:0] r, input logic [2:0] rf);
		pm.mem[{5'h00, w[6:0]}] = fv;
		lcase(w, wv, fl, w[7] ? wv : r, rf);
		chk({24'h0, pm.mem[{5'h00, w[6:0]}]}, {24'h0, w[7] ? r : fv});
	endtask

	// Skip candidate, then an add of 0xF0, then a latch load that must run
	task automatic scase(input logic [13:0] w, input logic [7:0] fv, input logic [7:0] r,
		input logic sk);
		pm.mem[{5'h00, w[6:0]}] = fv;
		wb(1'b1, OFF_ACCUM, 32'h10);
		wb(1'b1, OFF_FLAGS, 32'h0);
		push(w);
		push(14'h3EF0);
		push(14'h31AA);
		settle();
		chk({24'h0, pm.mem[{5'h00, w[6:0]}]}, {24'h0, r});
		wb(1'b0, OFF_ACCUM, 32'h0);
		chk(q, sk ? 32'h10 : 32'h00);
		wb(1'b0, OFF_FLAGS, 32'h0);
		chk(q, sk ? 32'h0 : 32'h5);
		wb(1'b0, OFF_UPPER_LATCH, 32'h0);
		chk(q, 32'h2A);
	endtask

	// Indirect read through a pointer, then a no-op to time the gap
	task automatic icase(input logic [7:0] a, input logic [15:0] p, input logic [6:0] f,
		input int g);
		wb(1'b1, a, {16'h0, p});
		wb(1'b1, OFF_ACCUM, 32'h0);
		pm.mem[p[11:0]] = 8'h3C;
		push({7'b0001000, f});
		push(14'h0000);
		settle();
		chk({16'h0, pm.rd_addr}, {16'h0, p});
		chk(pm.gap, g);
		wb(1'b0, OFF_ACCUM, 32'h0);
		chk(q, 32'h3C);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_reset();
		logic [7:0] offs [7];
		offs = '{OFF_ACCUM, OFF_FLAGS, OFF_BANK, OFF_UPPER_LATCH, OFF_PTR0, OFF_PTR1, 8'h40};
		wb(1'b0, OFF_CTRL, 32'h0);
		chk(q, {31'h0, RUN_RST});
		foreach (offs[i]) begin
			wb(1'b0, offs[i], 32'h0);
			chk(q, 32'h0);
		end
	endtask

	// Move to file in bank 3, top address: read still happens
	task automatic t_bank();
		int n0;
		wb(1'b1, OFF_BANK, 32'h3);
		wb(1'b1, OFF_ACCUM, 32'hA5);
		pm.mem[12'h1FF] = 8'h00;
		n0 = pm.n_rd;
		push({7'b0000001, 7'h7F});
		settle();
		chk(pm.n_rd - n0, 32'h1);
		chk({16'h0, pm.rd_addr}, 32'h01FF);
		chk({24'h0, pm.mem[12'h1FF]}, 32'hA5);
		wb(1'b0, OFF_EXEC_STATUS, 32'h0);
		chk(q, 32'h0000FF00);
		wb(1'b1, OFF_BANK, 32'h0);
	endtask

	// Every bit, both tests, bit set and bit clear
	task automatic t_bits();
		logic [7:0] v;
		for (int b = 0; b < 8; b++) begin
			for (int k = 0; k < 4; k++) begin
				v = k[0] ? ~(8'h01 << b) : (8'h01 << b);
				scase({3'b011, k[1], b[2:0], 7'h34}, v, v, v[b] == k[1]);
			end
		end
	endtask

	// ********
	// Main sequence
	// ********
	initial begin
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'hF;
		wb_dat = 32'h0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		fcase({7'b0001000, 7'h20}, 8'h0F, 8'hF0, 3'b011, 8'hFF, 3'b011);
		fcase({7'b0001001, 7'h21}, 8'h00, 8'h00, 3'b011, 8'h00, 3'b111);
		fcase({7'b0001101, 7'h22}, 8'h5A, 8'h5A, 3'b001, 8'h00, 3'b101);
		fcase({7'b0011011, 7'h23}, 8'h81, 8'h00, 3'b110, 8'h02, 3'b111);
		fcase({7'b0011000, 7'h24}, 8'h01, 8'h00, 3'b011, 8'h80, 3'b011);
		fcase({7'b1111011, 7'h25}, 8'h80, 8'h7F, 3'b001, 8'h00, 3'b111);
		fcase({7'b1110111, 7'h26}, 8'h05, 8'h05, 3'b001, 8'h00, 3'b111);
		fcase({7'b1110110, 7'h27}, 8'h10, 8'h01, 3'b110, 8'h0E, 3'b001);
		lcase(14'h3E2C, 8'hD4, 3'b000, 8'h00, 3'b111);
		lcase(14'h3C05, 8'h06, 3'b111, 8'hFF, 3'b000);
		lcase(14'h390F, 8'hF0, 3'b011, 8'h00, 3'b111);
		lcase(14'h3881, 8'h18, 3'b111, 8'h99, 3'b011);
		lcase(14'h3AFF, 8'h0F, 3'b101, 8'hF0, 3'b001);
		lcase(14'h0103, 8'h37, 3'b011, 8'h00, 3'b111);
		lcase({7'b1100011, 7'h55}, 8'h12, 3'b101, 8'h12, 3'b101);
		wb(1'b0, OFF_UPPER_LATCH, 32'h0);
		chk(q, 32'h55);
		fcase({4'b0101, 3'd5, 7'h28}, 8'h00, 8'h33, 3'b101, 8'h20, 3'b101);
		fcase({4'b0100, 3'd3, 7'h29}, 8'hFF, 8'h33, 3'b010, 8'hF7, 3'b010);
		fcase({7'b0001110, 7'h40}, 8'h08, 8'h08, 3'b000, 8'h10, 3'b010);
		fcase({7'b0000101, 7'h41}, 8'h03, 8'h05, 3'b111, 8'hFE, 3'b000);
		fcase({7'b1101111, 7'h42}, 8'h81, 8'h00, 3'b010, 8'hC0, 3'b011);
		fcase({7'b1101010, 7'h43}, 8'h80, 8'h77, 3'b000, 8'h00, 3'b101);
		fcase({7'b1101101, 7'h44}, 8'h01, 8'h00, 3'b000, 8'h00, 3'b101);
		fcase({7'b0011101, 7'h45}, 8'hA5, 8'h00, 3'b111, 8'h5A, 3'b111);
		fcase({7'b0010010, 7'h46}, 8'hFF, 8'h21, 3'b000, 8'h00, 3'b100);
		fcase({7'b0000111, 7'h47}, 8'h01, 8'h00, 3'b011, 8'h00, 3'b111);
		fcase({7'b0010100, 7'h48}, 8'hFF, 8'h12, 3'b000, 8'h00, 3'b100);
		fcase({7'b0010000, 7'h49}, 8'h00, 8'h55, 3'b000, 8'h00, 3'b100);
		fcase({7'b0001011, 7'h4A}, 8'hF0, 8'h3C, 3'b111, 8'h30, 3'b011);
		fcase({7'b0000011, 7'h4B}, 8'h55, 8'h66, 3'b000, 8'h00, 3'b100);
		lcase(14'h3077, 8'h00, 3'b101, 8'h77, 3'b101);
		scase({7'b0010111, 7'h30}, 8'h01, 8'h00, 1'b1);
		scase({7'b0010111, 7'h31}, 8'h02, 8'h01, 1'b0);
		scase({7'b0011111, 7'h32}, 8'hFF, 8'h00, 1'b1);
		scase({7'b0011111, 7'h33}, 8'h05, 8'h06, 1'b0);
		t_bits();
		lcase(14'h0025, 8'h11, 3'b010, 8'h11, 3'b010);
		wb(1'b0, OFF_BANK, 32'h0);
		chk(q, 32'h05);
		t_bank();
		icase(OFF_PTR1, 16'h8025, 7'h01, 8);
		icase(OFF_PTR0, 16'h0030, 7'h00, 4);
		test_done();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#150000;
		chk(32'h0, 32'h1);
		test_done();
	end
endmodule // testbench
